// File: shared/port9_pkg.sv
// Constants shared by the six-pin port with serial pin sharing.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`default_nettype none

package port9_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] DIR_INDEX    = 16'hffd0;
    localparam logic [15:0] DATA_INDEX   = 16'hffd2;
    localparam logic [15:0] SERIAL_INDEX = 16'hffd4;
    localparam int          ADDR_W       = 18;
    localparam logic [17:0] DIR_ADDR     = {DIR_INDEX, 2'b00};
    localparam logic [17:0] DATA_ADDR    = {DATA_INDEX, 2'b00};
    localparam logic [17:0] SERIAL_ADDR  = {SERIAL_INDEX, 2'b00};

    // ------------------------------------------------------------------
    // Reset values and fixed read values
    // ------------------------------------------------------------------
    localparam logic [7:0]  PORT_RESET   = 8'hc0;
    localparam logic [7:0]  RSVD_MASK    = 8'hc0;
    localparam logic [7:0]  DIR_READ     = 8'hff;
    localparam logic [12:0] SERIAL_RESET = 13'h0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Serial configuration register field positions
    // ------------------------------------------------------------------
    localparam int CH0_CLK_EN0   = 0;
    localparam int CH0_CLK_EN1   = 1;
    localparam int CH0_SYNC_SEL  = 2;
    localparam int CH0_RX_ON     = 3;
    localparam int CH0_TX_ON     = 4;
    localparam int CH1_CLK_EN0   = 5;
    localparam int CH1_CLK_EN1   = 6;
    localparam int CH1_SYNC_SEL  = 7;
    localparam int CH1_RX_ON     = 8;
    localparam int CH1_TX_ON     = 9;
    localparam int SMARTCARD_SEL = 10;
    localparam int EXT_INTERRUPT_4_EN       = 11;
    localparam int EXT_INTERRUPT_5_EN       = 12;
    localparam int SERIAL_W      = 13;

endpackage

`default_nettype wire

// File: core/clock_pin_mux.sv
// Function selection for a pin shared with a serial clock.
// Assumes registered use of its outputs by the port top.
`default_nettype none
`timescale 1ns/10ps

module clock_pin_mux (
    input  wire logic clk_enable_bit1,
    input  wire logic clk_enable_bit0,
    input  wire logic sync_async_select,
    input  wire logic dir_bit,
    input  wire logic data_bit,
    input  wire logic clk_out,
    output logic      pin_drive,
    output logic      pin_enable,
    output logic      clk_in_sel
);

    // ------------------------------------------------------------------
    // Clock input beats clock output, which beats plain I/O.
    // ------------------------------------------------------------------
    always_comb begin
        clk_in_sel = clk_enable_bit1;
        if (clk_enable_bit1) begin
            pin_drive  = 1'b0;
            pin_enable = 1'b0;
        end else if (sync_async_select || clk_enable_bit0) begin
            pin_drive  = clk_out;
            pin_enable = 1'b1;
        end else begin
            pin_drive  = data_bit;
            pin_enable = dir_bit;
        end
    end

endmodule // clock_pin_mux

`default_nettype wire

// File: core/data_pin_mux.sv
// Function selection for a pin shared with serial receive or transmit.
// Assumes registered use of its outputs by the port top.
`default_nettype none
`timescale 1ns/10ps

module data_pin_mux (
    input  wire logic periph_in_sel,
    input  wire logic periph_out_sel,
    input  wire logic periph_out,
    input  wire logic periph_enable,
    input  wire logic dir_bit,
    input  wire logic data_bit,
    output logic      pin_drive,
    output logic      pin_enable
);

    // ------------------------------------------------------------------
    // A serial function takes the pin, else the direction bit decides.
    // ------------------------------------------------------------------
    always_comb begin
        if (periph_out_sel) begin
            pin_drive  = periph_out;
            pin_enable = periph_enable;
        end else if (periph_in_sel) begin
            pin_drive  = 1'b0;
            pin_enable = 1'b0;
        end else begin
            pin_drive  = data_bit;
            pin_enable = dir_bit;
        end
    end

endmodule // data_pin_mux

`default_nettype wire

// File: core/port9_io.sv
// Six-pin I/O port sharing pins with two serial channels and two
// external interrupt inputs, with Avalon-MM register access.
// Assumes pins and serial signals are synchronous to core_clk.
//
// Notes on behaviour
// [RL1] Eight-bit data register; pins set as outputs drive its bits.
// [RL2] Reading the port returns the data bit where direction is one.
// [RL3] Reading the port returns the pin level where direction is zero.
// [RL4] Data bits 7 and 6 cannot be written and read as one.
// [RL5] Data register loads c0 on reset and during hardware standby.
// [RL6] Data register holds its contents during software standby.
// [RL7] Pin 5: channel 1 clock input, else clock output, else plain I/O.
// [RL8] Pin 4: same clock selection using channel 0 bits.
// [RL9] Pin 3: channel 1 receive input when enabled, else plain I/O.
// [RL10] Pin 2: channel 0 receive input on smartcard or receive enable.
// [RL11] Pin 1: channel 1 transmit output when enabled, else plain I/O.
// [RL12] Pin 0: channel 0 transmit output on enable or smartcard.
// [RL13] Smartcard transmit on pin 0 is either driven or released.
// [RL14] As plain I/O, direction one means output, zero means input.
// [RL15] Direction register is write-only and reads as all ones.
// [RL16] Direction resets to c0, holds in software standby.
// [RL17] Interrupt inputs 5 and 4 follow only their enable bits.
`default_nettype none
`timescale 1ns/10ps

module port9_io (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        hw_standby,
    input  wire logic        sw_standby,
    input  wire logic [17:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [5:0]  pin_in,
    output logic      [5:0]  pin_out,
    output logic      [5:0]  pin_oe,
    input  wire logic        ch0_clk_out,
    input  wire logic        ch1_clk_out,
    input  wire logic        ch0_tx_data,
    input  wire logic        ch1_tx_data,
    input  wire logic        ch0_tx_drive,
    output logic             ch0_clk_in,
    output logic             ch1_clk_in,
    output logic             receive_line_0,
    output logic             receive_line_1,
    output logic             ext_interrupt_5_n,
    output logic             ext_interrupt_4_n
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0]  port9_direction_reg;
    logic [7:0]  port9_direction_next;
    logic [7:0]  port9_output_reg;
    logic [7:0]  port9_output_next;
    logic [12:0] serial_cfg_reg;
    logic [12:0] serial_cfg_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic        waitrequest_reg;
    logic        waitrequest_next;
    logic        wr_take;
    logic        rd_start;

    assign wr_take  = write && !waitrequest_reg && byteenable[0]
                      && !sw_standby;
    assign rd_start = read && waitrequest_reg;

    always_comb begin
        port9_direction_next = port9_direction_reg;
        port9_output_next    = port9_output_reg;
        serial_cfg_next      = serial_cfg_reg;
        readdata_next        = readdata_reg;
        waitrequest_next     = !((read || write) && waitrequest_reg);
        if (wr_take) begin
            case (address)
                port9_pkg::DIR_ADDR: begin
                    port9_direction_next = writedata[7:0]
                                           | port9_pkg::RSVD_MASK; // RL16
                end
                port9_pkg::DATA_ADDR: begin
                    port9_output_next = writedata[7:0]
                                        | port9_pkg::RSVD_MASK; // RL4
                end
                port9_pkg::SERIAL_ADDR: begin
                    serial_cfg_next = writedata[12:0];
                end
                default: begin
                    serial_cfg_next = serial_cfg_reg;
                end
            endcase
        end
        if (rd_start) begin
            case (address)
                port9_pkg::DIR_ADDR: begin
                    readdata_next = {24'h000000, port9_pkg::DIR_READ}; // RL15
                end
                port9_pkg::DATA_ADDR: begin
                    readdata_next = {24'h000000, port9_pkg::RSVD_MASK[7:6],
                        (port9_direction_reg[5:0] & port9_output_reg[5:0])
                        | (~port9_direction_reg[5:0] & pin_in)}; // RL2 RL3
                end
                port9_pkg::SERIAL_ADDR: begin
                    readdata_next = {19'h00000, serial_cfg_reg};
                end
                default: begin
                    readdata_next = port9_pkg::UNMAPPED_READ;
                end
            endcase
        end
        if (hw_standby) begin
            port9_direction_next = port9_pkg::PORT_RESET; // RL16
            port9_output_next    = port9_pkg::PORT_RESET; // RL5
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port9_direction_reg <= port9_pkg::PORT_RESET; // RL16
            port9_output_reg    <= port9_pkg::PORT_RESET; // RL5
            serial_cfg_reg      <= port9_pkg::SERIAL_RESET;
            readdata_reg        <= 32'h0000_0000;
            waitrequest_reg     <= 1'b1;
        end else begin
            port9_direction_reg <= port9_direction_next;
            port9_output_reg    <= port9_output_next; // RL6
            serial_cfg_reg      <= serial_cfg_next;
            readdata_reg        <= readdata_next;
            waitrequest_reg     <= waitrequest_next;
        end
    end

    assign readdata    = readdata_reg;
    assign waitrequest = waitrequest_reg;

    // ------------------------------------------------------------------
    // Pin function selection
    // ------------------------------------------------------------------
    logic [5:0] mux_drive;
    logic [5:0] mux_enable;
    logic       clk1_sel;
    logic       clk0_sel;
    logic       rx0_sel;
    logic       tx0_sel;
    logic       smart;

    assign smart   = serial_cfg_reg[port9_pkg::SMARTCARD_SEL];
    assign rx0_sel = smart || serial_cfg_reg[port9_pkg::CH0_RX_ON];
    assign tx0_sel = smart || serial_cfg_reg[port9_pkg::CH0_TX_ON];

    clock_pin_mux pin5_mux ( // RL7
        .clk_enable_bit1   (serial_cfg_reg[port9_pkg::CH1_CLK_EN1]),
        .clk_enable_bit0   (serial_cfg_reg[port9_pkg::CH1_CLK_EN0]),
        .sync_async_select (serial_cfg_reg[port9_pkg::CH1_SYNC_SEL]),
        .dir_bit           (port9_direction_reg[5]),
        .data_bit          (port9_output_reg[5]),
        .clk_out           (ch1_clk_out),
        .pin_drive         (mux_drive[5]),
        .pin_enable        (mux_enable[5]),
        .clk_in_sel        (clk1_sel)
    );

    clock_pin_mux pin4_mux ( // RL8
        .clk_enable_bit1   (serial_cfg_reg[port9_pkg::CH0_CLK_EN1]),
        .clk_enable_bit0   (serial_cfg_reg[port9_pkg::CH0_CLK_EN0]),
        .sync_async_select (serial_cfg_reg[port9_pkg::CH0_SYNC_SEL]),
        .dir_bit           (port9_direction_reg[4]),
        .data_bit          (port9_output_reg[4]),
        .clk_out           (ch0_clk_out),
        .pin_drive         (mux_drive[4]),
        .pin_enable        (mux_enable[4]),
        .clk_in_sel        (clk0_sel)
    );

    data_pin_mux pin3_mux ( // RL9
        .periph_in_sel  (serial_cfg_reg[port9_pkg::CH1_RX_ON]),
        .periph_out_sel (1'b0),
        .periph_out     (1'b0),
        .periph_enable  (1'b0),
        .dir_bit        (port9_direction_reg[3]),
        .data_bit       (port9_output_reg[3]),
        .pin_drive      (mux_drive[3]),
        .pin_enable     (mux_enable[3])
    );

    data_pin_mux pin2_mux ( // RL10
        .periph_in_sel  (rx0_sel),
        .periph_out_sel (1'b0),
        .periph_out     (1'b0),
        .periph_enable  (1'b0),
        .dir_bit        (port9_direction_reg[2]),
        .data_bit       (port9_output_reg[2]),
        .pin_drive      (mux_drive[2]),
        .pin_enable     (mux_enable[2])
    );

    data_pin_mux pin1_mux ( // RL11
        .periph_in_sel  (1'b0),
        .periph_out_sel (serial_cfg_reg[port9_pkg::CH1_TX_ON]),
        .periph_out     (ch1_tx_data),
        .periph_enable  (1'b1),
        .dir_bit        (port9_direction_reg[1]),
        .data_bit       (port9_output_reg[1]),
        .pin_drive      (mux_drive[1]),
        .pin_enable     (mux_enable[1])
    );

    data_pin_mux pin0_mux ( // RL12
        .periph_in_sel  (1'b0),
        .periph_out_sel (tx0_sel),
        .periph_out     (ch0_tx_data),
        .periph_enable  (!smart || ch0_tx_drive), // RL13
        .dir_bit        (port9_direction_reg[0]),
        .data_bit       (port9_output_reg[0]),
        .pin_drive      (mux_drive[0]),
        .pin_enable     (mux_enable[0])
    );

    // ------------------------------------------------------------------
    // Registered pin and serial side outputs
    // ------------------------------------------------------------------
    logic [5:0] pin_out_reg;
    logic [5:0] pin_out_next;
    logic [5:0] pin_oe_reg;
    logic [5:0] pin_oe_next;
    logic [5:0] side_reg;
    logic [5:0] side_next;

    always_comb begin
        pin_out_next = mux_drive; // RL1
        pin_oe_next  = hw_standby ? 6'h00 : mux_enable; // RL14
        side_next[0] = clk0_sel ? pin_in[4] : 1'b0;
        side_next[1] = clk1_sel ? pin_in[5] : 1'b0;
        side_next[2] = rx0_sel ? pin_in[2] : 1'b1;
        side_next[3] = serial_cfg_reg[port9_pkg::CH1_RX_ON] ? pin_in[3]
                                                              : 1'b1;
        side_next[4] = serial_cfg_reg[port9_pkg::EXT_INTERRUPT_5_EN] ? pin_in[5]
                                                            : 1'b1; // RL17
        side_next[5] = serial_cfg_reg[port9_pkg::EXT_INTERRUPT_4_EN] ? pin_in[4]
                                                            : 1'b1; // RL17
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_out_reg <= 6'h00;
            pin_oe_reg  <= 6'h00;
            side_reg    <= 6'h3c;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
            side_reg    <= side_next;
        end
    end

    assign pin_out           = pin_out_reg;
    assign pin_oe            = pin_oe_reg;
    assign ch0_clk_in        = side_reg[0];
    assign ch1_clk_in        = side_reg[1];
    assign receive_line_0    = side_reg[2];
    assign receive_line_1    = side_reg[3];
    assign ext_interrupt_5_n = side_reg[4];
    assign ext_interrupt_4_n = side_reg[5];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence data_rd_s;
        read && waitrequest && address == port9_pkg::DATA_ADDR;
    endsequence

    sequence rd_done_s;
        !waitrequest ##1 waitrequest;
    endsequence

    port_rd_out_a: assert property (data_rd_s |=> // RL2
        ((readdata[5:0] & $past(port9_direction_reg[5:0]))
         == ($past(port9_output_reg[5:0])
             & $past(port9_direction_reg[5:0]))) and rd_done_s)
        else $error("read of output pin not from data register");

    port_rd_in_a: assert property (data_rd_s |=> // RL3
        (readdata[5:0] & ~$past(port9_direction_reg[5:0]))
        == ($past(pin_in) & ~$past(port9_direction_reg[5:0])))
        else $error("read of input pin not from pin level");

    rsvd_bits_a: assert property (data_rd_s |=> // RL4
        readdata[7:6] == 2'b11 && port9_output_reg[7:6] == 2'b11)
        else $error("reserved data bits not one");

    hw_stby_data_a: assert property (hw_standby |=> // RL5
        port9_output_reg == 8'hc0 && pin_oe == 6'h00)
        else $error("hardware standby did not clear data");

    sw_stby_hold_a: assert property (sw_standby && !hw_standby |=> // RL6
        $stable(port9_output_reg) && $stable(port9_direction_reg))
        else $error("software standby changed port registers");

    dir_rd_ones_a: assert property ( // RL15
        read && waitrequest && address == port9_pkg::DIR_ADDR
        |=> readdata[7:0] == 8'hff)
        else $error("direction read not all ones");

    hw_stby_dir_a: assert property (hw_standby |=> // RL16
        port9_direction_reg == 8'hc0)
        else $error("hardware standby did not reset direction");

    clk_in_pin5_a: assert property ( // RL7
        serial_cfg_reg[port9_pkg::CH1_CLK_EN1]
        |=> !pin_oe[5] && ch1_clk_in == $past(pin_in[5]))
        else $error("pin 5 not a clock input");

    tx1_drive_a: assert property ( // RL11
        serial_cfg_reg[port9_pkg::CH1_TX_ON] && !hw_standby
        |=> pin_oe[1] && pin_out[1] == $past(ch1_tx_data))
        else $error("pin 1 not driving transmit data");

    smart_tx_a: assert property ( // RL13
        smart && !hw_standby |=> pin_oe[0] == $past(ch0_tx_drive))
        else $error("smartcard pin 0 enable wrong");

    plain_io3_a: assert property ( // RL14
        !serial_cfg_reg[port9_pkg::CH1_RX_ON] && !hw_standby
        |=> pin_oe[3] == $past(port9_direction_reg[3])
            && pin_out[3] == $past(port9_output_reg[3]))
        else $error("pin 3 plain I/O wrong");

    ext_interrupt_5_follow_a: assert property ( // RL17
        serial_cfg_reg[port9_pkg::EXT_INTERRUPT_5_EN]
        |=> ext_interrupt_5_n == $past(pin_in[5]))
        else $error("interrupt 5 does not follow pin");

endmodule // port9_io

`default_nettype wire

// File: verification/board_pins.sv
// Board model for the six port pins: external drivers and pull-ups.
// Assumes an enabled board driver overrides the port's own driver.
`default_nettype none
`timescale 1ns/10ps

module board_pins (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] ext_level,
    input  wire logic [5:0] ext_en,
    output logic      [5:0] pin_in
);
    // ------------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------------
    // A pin that nobody drives floats high through its pull-up.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_in[i] = ext_en[i] ? ext_level[i]
                                  : (pin_oe[i] ? pin_out[i] : 1'b1);
        end
    end
endmodule // board_pins

`default_nettype wire

// File: verification/port9_io_tb.sv
// Self-checking bench for the six-pin port with serial pin sharing.
// Assumes the port package and the board model are compiled first.
`default_nettype none
`timescale 1ns/10ps

module port9_io_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        core_clk   = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        hw_standby = 1'b0;
    logic        sw_standby = 1'b0;
    logic [17:0] address    = '0;
    logic        read       = 1'b0;
    logic        write      = 1'b0;
    logic [31:0] writedata  = '0;
    logic [3:0]  byteenable = 4'h1;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [5:0]  pin_in, pin_out, pin_oe;
    logic [5:0]  ext_level  = '0;
    logic [5:0]  ext_en     = '0;
    logic [4:0]  side_in    = '0;
    logic [5:0]  side_out;
    logic [31:0] exp_q[$];
    logic [31:0] seed       = 32'h0000_0063;
    int          fails      = 0;
    int          n_tests    = 0;
    int          cycles     = 0;

    always #5 core_clk = ~core_clk;

    port9_io dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .ch0_tx_data(side_in[0]),
        .ch1_tx_data(side_in[1]), .ch0_clk_out(side_in[2]),
        .ch1_clk_out(side_in[3]), .ch0_tx_drive(side_in[4]),
        .ch1_clk_in(side_out[5]), .ch0_clk_in(side_out[4]),
        .receive_line_1(side_out[3]), .receive_line_0(side_out[2]),
        .ext_interrupt_5_n(side_out[1]), .ext_interrupt_4_n(side_out[0])
    );

    board_pins board (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .ext_en(ext_en), .pin_in(pin_in)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low, then idles a cycle.
    task automatic bus(input logic wr, input logic [17:0] a,
                       input logic [31:0] d);
        read      <= !wr;
        write     <= wr;
        address   <= a;
        writedata <= d;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, '0);
    endtask

    // Expected {oe, driven out, side outputs} from the selection rules.
    function automatic logic [31:0] pins_model(logic [12:0] c,
        logic [5:0] dr, logic [5:0] dt, logic [5:0] x, logic [4:0] s);
        logic [5:0] oe;
        logic [5:0] o;
        logic [5:0] sd;
        oe = dr;
        o  = dt;
        if (c[port9_pkg::CH1_CLK_EN1]) oe[5] = 1'b0;
        else if (c[port9_pkg::CH1_SYNC_SEL] | c[port9_pkg::CH1_CLK_EN0])
            {oe[5], o[5]} = {1'b1, s[3]};
        if (c[port9_pkg::CH0_CLK_EN1]) oe[4] = 1'b0;
        else if (c[port9_pkg::CH0_SYNC_SEL] | c[port9_pkg::CH0_CLK_EN0])
            {oe[4], o[4]} = {1'b1, s[2]};
        if (c[port9_pkg::CH1_RX_ON]) oe[3] = 1'b0;
        if (c[port9_pkg::SMARTCARD_SEL] | c[port9_pkg::CH0_RX_ON])
            oe[2] = 1'b0;
        if (c[port9_pkg::CH1_TX_ON]) {oe[1], o[1]} = {1'b1, s[1]};
        if (c[port9_pkg::SMARTCARD_SEL]) {oe[0], o[0]} = {s[4], s[0]};
        else if (c[port9_pkg::CH0_TX_ON]) {oe[0], o[0]} = {1'b1, s[0]};
        sd[5] = c[port9_pkg::CH1_CLK_EN1] ? x[5] : 1'b0;
        sd[4] = c[port9_pkg::CH0_CLK_EN1] ? x[4] : 1'b0;
        sd[3] = c[port9_pkg::CH1_RX_ON] ? x[3] : 1'b1;
        sd[2] = (c[port9_pkg::SMARTCARD_SEL] | c[port9_pkg::CH0_RX_ON])
                ? x[2] : 1'b1;
        sd[1] = c[port9_pkg::EXT_INTERRUPT_5_EN] ? x[5] : 1'b1;
        sd[0] = c[port9_pkg::EXT_INTERRUPT_4_EN] ? x[4] : 1'b1;
        return {14'h0, oe, o & oe, sd};
    endfunction

    // ------------------------------------------------------------------
    // Read-result watcher and timeout
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            check(readdata, exp_q.pop_front());
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] c, d, r, x;
        repeat (4) @(posedge core_clk);
        sys_rst   <= 1'b0;
        @(posedge core_clk);
        ext_en    <= 6'h3f;
        ext_level <= 6'h2a;
        rd(port9_pkg::DIR_ADDR, 32'hff);
        rd(port9_pkg::DATA_ADDR, 32'hea);
        rd(18'h0, 32'h0);
        check({26'h0, pin_oe}, 32'h0);
        for (int i = 0; i < 40; i++) begin
            c = (i < 13) ? (32'h1 << i) : rnd();
            d = rnd();
            r = rnd();
            x = rnd();
            ext_level <= x[5:0];
            side_in   <= x[12:8];
            bus(1'b1, port9_pkg::SERIAL_ADDR, c & 32'h1fff);
            bus(1'b1, port9_pkg::DIR_ADDR, d & 32'hff);
            bus(1'b1, port9_pkg::DATA_ADDR, r & 32'hff);
            rd(port9_pkg::DATA_ADDR, {24'h0, 2'b11,
               (d[5:0] & r[5:0]) | (~d[5:0] & x[5:0])});
            repeat (2) @(posedge core_clk);
            check({14'h0, pin_oe, pin_out & pin_oe, side_out},
                  pins_model(c[12:0], d[5:0], r[5:0], x[5:0],
                  x[12:8]));
        end
        bus(1'b1, port9_pkg::SERIAL_ADDR, 32'h0);
        bus(1'b1, port9_pkg::DIR_ADDR, 32'h15);
        bus(1'b1, port9_pkg::DATA_ADDR, 32'h05);
        ext_level  <= 6'h28;
        sw_standby <= 1'b1;
        bus(1'b1, port9_pkg::DIR_ADDR, 32'h2a);
        bus(1'b1, port9_pkg::DATA_ADDR, 32'h3a);
        rd(port9_pkg::DATA_ADDR, 32'hed);
        check({26'h0, pin_oe}, 32'h15);
        check({26'h0, pin_out & 6'h15}, 32'h05);
        sw_standby <= 1'b0;
        hw_standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        check({26'h0, pin_oe}, 32'h0);
        hw_standby <= 1'b0;
        byteenable <= 4'h0;
        @(posedge core_clk);
        bus(1'b1, port9_pkg::DIR_ADDR, 32'h3f);
        byteenable <= 4'h1;
        rd(port9_pkg::DATA_ADDR, 32'he8);
        repeat (2) @(posedge core_clk);
        check({26'h0, pin_oe}, 32'h0);
        bus(1'b1, port9_pkg::DIR_ADDR, 32'h3f);
        rd(port9_pkg::DATA_ADDR, 32'hc0);
        report_and_stop();
    end
endmodule // port9_io_tb

`default_nettype wire
